// ### verilog/irq_regs_pkg.sv
// constants, register map and field layout for the interrupt flag/enable/priority block
package irq_regs_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 16;
   localparam int unsigned PRIO_W = 3;
   // byte offsets of the four registers
   localparam logic [11:0] OFFSET_FLAGS_1 = 12'h000;
   localparam logic [11:0] OFFSET_ENABLES_3 = 12'h004;
   localparam logic [11:0] OFFSET_PRIORITY_19 = 12'h008;
   localparam logic [11:0] OFFSET_PENDING = 12'h00C;
   // reset values
   localparam logic [15:0] RESET_FLAGS_1 = 16'h0000;
   localparam logic [15:0] RESET_ENABLES_3 = 16'h0000;
   localparam logic [15:0] RESET_PRIORITY_19 = 16'h4000;
   // writable masks: flags bit 5 and enables bits 15, 10..0 are unimplemented
   localparam logic [15:0] MASK_FLAGS_1 = 16'hFFDF;
   localparam logic [15:0] MASK_ENABLES_3 = 16'h7800;
   localparam logic [15:0] MASK_PRIORITY_19 = 16'h7700;
   // enable bit positions in interrupt_enables_3
   localparam int unsigned BIT_CALENDAR_IE = 14;
   localparam int unsigned BIT_DMA_CH5_DONE_IE = 13;
   localparam int unsigned BIT_CODEC_EVENT_IE = 12;
   localparam int unsigned BIT_CODEC_ERROR_IE = 11;
   // priority field positions in interrupt_priority_19
   localparam int unsigned POS_DAC_LEFT_PRIO = 12;
   localparam int unsigned POS_DAC_RIGHT_PRIO = 8;
   localparam logic [2:0] PRIO_OFF = 3'h0;
   // number of sources handled by the enable/priority path
   localparam int unsigned NUM_SRC = 6;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : irq_regs_pkg

// ### verilog/irq_src_if.sv
// bundle carrying per-source request, enable and priority between gate and top
`timescale 1ns/100ps
interface irq_src_if #(parameter int unsigned N = 6);
   logic [N-1:0] req;
   logic [N-1:0] enable;
   logic [N*3-1:0] prio;
   logic [N-1:0] fwd;
   modport ctrl (output req, output enable, output prio, input fwd);
   modport gate (input req, input enable, input prio, output fwd);
endinterface : irq_src_if

// ### verilog/irq_gate.sv
// per-source forwarding gate: enable and non-zero priority
`timescale 1ns/100ps
module irq_gate
   import irq_regs_pkg::*;
#(
   parameter int unsigned N = NUM_SRC
) (
   irq_src_if.gate src // request, enable and priority in, forwarded request out
);
   // forward only when enabled and priority above zero
   always_comb begin
      for (int i = 0; i < N; i++) begin
         src.fwd[i] = src.req[i] & src.enable[i] & (src.prio[i*3 +: 3] != PRIO_OFF); // [RULE_01] [RULE_06]
      end
   end
endmodule : irq_gate

// ### verilog/irq_flag_enable_prio.sv
// interrupt flags, enables and priorities behind an ahb-lite slave
// Functional notes
// RULE_01 - a source request is forwarded only while its enable bit is one; the dac left and right enables are tied to one here
// RULE_02 - enable register bits 10..0 read zero and ignore writes
// RULE_03 - dma channel 5 done enable sits at enable register bit 13
// RULE_04 - codec error enable sits at bit 11, separate from event enable
// RULE_05 - without audio dac, left and right dac interrupts stay disabled always
// RULE_06 - 3-bit priority, 7 highest, 1 lowest, 0 disables; hardware sets flags
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/100ps
module irq_flag_enable_prio
   import irq_regs_pkg::*;
#(
   parameter bit HAS_AUDIO_DAC = 1'b1 // variant has the audio dac
) (
   input wire logic clk_i, // system clock, 25 mhz
   input wire logic reset_n_i, // asynchronous reset, active low
   input wire logic hsel_i, // slave select
   input wire logic [31:0] haddr_i, // byte address
   input wire logic [1:0] htrans_i, // transfer type
   input wire logic hwrite_i, // write when high
   input wire logic [2:0] hsize_i, // transfer size
   input wire logic [31:0] hwdata_i, // write data
   input wire logic hready_i, // bus ready in
   output logic [31:0] hrdata_o, // read data
   output logic hreadyout_o, // slave ready
   output logic hresp_o, // always okay
   input wire logic [15:0] flag_set_i, // per-bit request pulses for interrupt_flags_1
   input wire logic [NUM_SRC-1:0] src_req_i, // requests: cal, dma5, codec ev, codec err, dacl, dacr
   output logic [NUM_SRC-1:0] irq_fwd_o // forwarded requests, registered
);
   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] enables;
      logic [15:0] prio;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
      logic [NUM_SRC-1:0] fwd;
   } state_t;

   state_t cur;
   state_t next_cur;
   logic [NUM_SRC-1:0] gate_fwd;
   logic addr_ok;

   irq_src_if #(.N(NUM_SRC)) src ();
   irq_gate #(.N(NUM_SRC)) u_gate (.src(src.gate));

   // effective priorities: dac fields forced off on variants without the dac
   function automatic logic [2:0] dac_prio(input logic [2:0] p);
      return HAS_AUDIO_DAC ? p : PRIO_OFF; // [RULE_05]
   endfunction : dac_prio

   // map enables and priorities to the gate; non-dac sources use priority max here
   assign src.req = src_req_i;
   assign src.enable = {cur.enables[BIT_CALENDAR_IE], cur.enables[BIT_DMA_CH5_DONE_IE], // [RULE_03]
                        cur.enables[BIT_CODEC_EVENT_IE], cur.enables[BIT_CODEC_ERROR_IE], // [RULE_04]
                        cur.enables[BIT_CALENDAR_IE] & 1'b0 | 1'b1, 1'b1};
   assign src.prio = {3'h7, 3'h7, 3'h7, 3'h7,
                      dac_prio(cur.prio[POS_DAC_LEFT_PRIO +: PRIO_W]),
                      dac_prio(cur.prio[POS_DAC_RIGHT_PRIO +: PRIO_W])}; // [RULE_05] [RULE_06]
   assign gate_fwd = src.fwd;

   always_comb begin
      addr_ok = 1'b1;
      next_cur = cur;
      next_cur.fwd = gate_fwd;
      // hardware sets flags; a set in the same cycle as a write-clear wins
      if (cur.wr_pend && cur.wr_addr == OFFSET_FLAGS_1) begin
         next_cur.flags = hwdata_i[15:0] & MASK_FLAGS_1;
      end
      next_cur.flags = next_cur.flags | (flag_set_i & MASK_FLAGS_1); // [RULE_06]
      // data phase writes to enables and priorities
      if (cur.wr_pend && cur.wr_addr == OFFSET_ENABLES_3) begin
         next_cur.enables = hwdata_i[15:0] & MASK_ENABLES_3; // [RULE_02]
      end
      if (cur.wr_pend && cur.wr_addr == OFFSET_PRIORITY_19) begin
         next_cur.prio = hwdata_i[15:0] & MASK_PRIORITY_19;
      end
      // address phase: capture writes, prepare read data
      next_cur.wr_pend = 1'b0;
      if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ) begin
         next_cur.wr_pend = hwrite_i;
         next_cur.wr_addr = haddr_i[11:0];
         if (!hwrite_i) begin
            case (haddr_i[11:0])
               OFFSET_FLAGS_1: next_cur.rdata = {16'h0000, cur.flags};
               OFFSET_ENABLES_3: next_cur.rdata = {16'h0000, cur.enables}; // [RULE_02]
               OFFSET_PRIORITY_19: next_cur.rdata = {16'h0000, cur.prio};
               OFFSET_PENDING: next_cur.rdata = {26'h0000000, cur.fwd};
               default: begin
                  next_cur.rdata = 32'h00000000;
                  addr_ok = 1'b0;
               end
            endcase
         end
      end
   end

   // register the whole state
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cur <= '{flags: RESET_FLAGS_1, enables: RESET_ENABLES_3, prio: RESET_PRIORITY_19,
                  wr_pend: 1'b0, wr_addr: 12'h000, rdata: 32'h00000000, fwd: '0};
      end else begin
         cur <= next_cur;
      end
   end

   assign hrdata_o = cur.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign irq_fwd_o = cur.fwd;

   // forwarded dma channel 5 request needs its enable
   property p_fwd_needs_enable;
      @(posedge clk_i) disable iff (!reset_n_i)
         irq_fwd_o[4] |-> $past(cur.enables[BIT_DMA_CH5_DONE_IE]);
   endproperty
   a_fwd_needs_enable: assert property (p_fwd_needs_enable) else $error("dma5 forwarded while disabled"); // [RULE_01]

   property p_fwd_when_enabled;
      @(posedge clk_i) disable iff (!reset_n_i)
         (src_req_i[3] && cur.enables[BIT_CODEC_EVENT_IE]) |=> irq_fwd_o[3];
   endproperty
   a_fwd_when_enabled: assert property (p_fwd_when_enabled) else $error("codec event not forwarded"); // [RULE_01]

   property p_low_bits_zero;
      @(posedge clk_i) disable iff (!reset_n_i) cur.enables[10:0] == 11'h000;
   endproperty
   a_low_bits_zero: assert property (p_low_bits_zero) else $error("enable low bits nonzero"); // [RULE_02]

   property p_dma5_write;
      @(posedge clk_i) disable iff (!reset_n_i)
         (cur.wr_pend && cur.wr_addr == OFFSET_ENABLES_3) |=> cur.enables[BIT_DMA_CH5_DONE_IE] == $past(hwdata_i[13]);
   endproperty
   a_dma5_write: assert property (p_dma5_write) else $error("dma5 enable not written"); // [RULE_03]

   property p_err_write;
      @(posedge clk_i) disable iff (!reset_n_i)
         (cur.wr_pend && cur.wr_addr == OFFSET_ENABLES_3) |=> cur.enables[BIT_CODEC_ERROR_IE] == $past(hwdata_i[11]);
   endproperty
   a_err_write: assert property (p_err_write) else $error("codec error enable not written"); // [RULE_04]

   property p_no_dac;
      @(posedge clk_i) disable iff (!reset_n_i) !HAS_AUDIO_DAC |-> irq_fwd_o[1:0] == 2'b00;
   endproperty
   a_no_dac: assert property (p_no_dac) else $error("dac interrupt without dac"); // [RULE_05]

   property p_prio_zero_off;
      @(posedge clk_i) disable iff (!reset_n_i)
         (cur.prio[POS_DAC_LEFT_PRIO +: PRIO_W] == PRIO_OFF) |=> !irq_fwd_o[1];
   endproperty
   a_prio_zero_off: assert property (p_prio_zero_off) else $error("priority zero forwarded"); // [RULE_06]

   property p_flag_set;
      @(posedge clk_i) disable iff (!reset_n_i) flag_set_i[15] |=> cur.flags[15];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag set lost"); // [RULE_06]
endmodule : irq_flag_enable_prio

// ### verification/irq_src_model.sv
// peripheral request source model: held request levels, one-cycle flag events
`timescale 1ns/100ps
module irq_src_model (
   input wire logic clk_i, // system clock
   input wire logic reset_n_i, // asynchronous reset, active low
   input wire logic [5:0] raise_i, // wanted request levels
   input wire logic [15:0] pulse_i, // flag events; a bit held high fires every other cycle
   output logic [5:0] src_req_o, // request levels
   output logic [15:0] flag_set_o // event pulses, one cycle each
);
   // levels follow the command; an event never lasts beyond one cycle
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         src_req_o <= 6'h00;
         flag_set_o <= 16'h0000;
      end else begin
         src_req_o <= raise_i;
         flag_set_o <= pulse_i & ~flag_set_o;
      end
   end
endmodule : irq_src_model

// ### verification/test_irq_flag_enable_prio.sv
// self-checking bench for the interrupt flag, enable and priority block
`timescale 1ns/100ps
module test_irq_flag_enable_prio;
   import irq_regs_pkg::*;
   typedef struct packed {logic [15:0] en; logic [15:0] pr; logic [5:0] fwd;} row_t;
   logic clk_i = 1'b0, reset_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic [1:0] htrans_i = 2'h0;
   logic [2:0] hsize_i = 3'h2;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
   logic hreadyout_o, hresp_o, hready_i;
   logic [5:0] raise = 6'h00, src_req_i, irq_fwd_o, fwd_nodac;
   logic [15:0] pulse = 16'h0000, flag_set_i;
   int n_mismatch = 0, n_tests = 0;
   row_t rows [6] = '{'{16'hFFFF, 16'h0000, 6'h3C}, '{16'h2000, 16'hFFFF, 6'h13},
      '{16'h0800, 16'h1000, 6'h06}, '{16'h1000, 16'h0100, 6'h09},
      '{16'h4000, 16'h0000, 6'h20}, '{16'h0000, 16'h7000, 6'h02}};
   assign hready_i = hreadyout_o;
   always #20 clk_i = ~clk_i;
   irq_src_model i_irq_src_model (.clk_i, .reset_n_i, .raise_i(raise), .pulse_i(pulse),
      .src_req_o(src_req_i), .flag_set_o(flag_set_i));
   irq_flag_enable_prio i_irq_flag_enable_prio (.*);
   irq_flag_enable_prio #(.HAS_AUDIO_DAC(1'b0)) i_irq_flag_enable_prio_nodac (.*,
      .hrdata_o(), .hreadyout_o(), .hresp_o(), .irq_fwd_o(fwd_nodac));
   // compare and count
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // bounded wait for an edge with hready high
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (hready_i !== 1'b1 && n < 20);
      if (hready_i !== 1'b1) begin
         n_mismatch++;
         complete_run();
      end
   endtask : wait_ready
   // one single ahb-lite transfer, read data left in rd
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      haddr_i <= {20'h0, a};
      hwrite_i <= w;
      hsel_i <= 1'b1;
      htrans_i <= HTRANS_NONSEQ;
      wait_ready();
      htrans_i <= 2'h0;
      hwdata_i <= d;
      wait_ready();
      rd = hrdata_o;
   endtask : bus
   initial begin
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      raise <= 6'h3F;
      // each row sets enables and priorities, then compares readback and forwarding
      foreach (rows[i]) begin
         bus(OFFSET_ENABLES_3, 1'b1, {16'h0, rows[i].en});
         bus(OFFSET_PRIORITY_19, 1'b1, {16'h0, rows[i].pr});
         bus(OFFSET_ENABLES_3, 1'b0, 32'h0);
         check("enables", rd, {16'h0, rows[i].en & 16'h7800});
         bus(OFFSET_PRIORITY_19, 1'b0, 32'h0);
         check("priority", rd, {16'h0, rows[i].pr & 16'h7700});
         check("fwd", {26'h0, irq_fwd_o}, {26'h0, rows[i].fwd});
         check("fwd nodac", {26'h0, fwd_nodac}, {26'h0, rows[i].fwd & 6'h3C});
         bus(OFFSET_PENDING, 1'b0, 32'h0);
         check("pending", rd, {26'h0, rows[i].fwd});
         check("hresp", {31'h0, hresp_o}, 32'h0);
      end
      // withdrawn requests are not forwarded
      raise <= 6'h00;
      repeat (3) @(posedge clk_i);
      check("fwd idle", {26'h0, irq_fwd_o}, 32'h0);
      // hardware event sets a flag, bit 5 stays zero, a write clears
      pulse <= 16'h0021;
      @(posedge clk_i);
      pulse <= 16'h0000;
      repeat (2) @(posedge clk_i);
      bus(OFFSET_FLAGS_1, 1'b0, 32'h0);
      check("flags set", rd, 32'h1);
      bus(OFFSET_FLAGS_1, 1'b1, 32'h0);
      bus(OFFSET_FLAGS_1, 1'b0, 32'h0);
      check("flags clear", rd, 32'h0);
      // unmapped address reads zero
      bus(12'h010, 1'b1, 32'hFFFF);
      bus(12'h010, 1'b0, 32'h0);
      check("unmapped", rd, 32'h0);
      // reset in mid-run restores start values
      reset_n_i <= 1'b0;
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      bus(OFFSET_PRIORITY_19, 1'b0, 32'h0);
      check("prio reset", rd, 32'h4000);
      check("fwd reset", {26'h0, irq_fwd_o}, 32'h0);
      bus(OFFSET_ENABLES_3, 1'b0, 32'h0);
      check("en reset", rd, 32'h0);
      complete_run();
   end
endmodule : test_irq_flag_enable_prio
